// ==== shared/buffer_cfg_pkg.sv ====
// Register map, field layout, reset values and threshold decoding for the channel buffer block
// Operation
// - Transmit channel interrupts go to the queue named by bits 31 to 29.
// - Transmit buffer gets as many 32-bit locations as bits 28 to 16 say; the code caps this at TX_DEPTH + 1.
// - Transmit locations are allocated on transmit init and released after transmit off.
// - Free locations reaching the refill threshold (bits 11 to 8) request new data.
// - Transmission waits until filled locations reach the forward threshold (bits 15 to 12).
// - A whole packet or packet end in the buffer is forwarded regardless of threshold.
// - Receive channel interrupts go to the queue named by bits 6 to 4.
// - Received data is forwarded at the threshold (bits 3 to 0) or packet end.
// - Receive codes 0 to 9 mean 1 to 64 DWORDs; higher codes are invalid.
// - Refill codes use the same table; codes 10 and above are invalid.
// - Forward codes accept all sixteen values, reaching up to 512 DWORDs.
// - Receive descriptor pointer is 30 bits in 31 to 2; low two bits read zero.
// - After the first receive request the whole descriptor is fetched and kept.
// - Receive abort/branch restarts the descriptor list at the pointer.
package buffer_cfg_pkg;

  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] CFG_OFFSET      = 12'h020;
  localparam logic [11:0] RDP_OFFSET      = 12'h024;
  localparam logic [11:0] STATUS_OFFSET   = 12'h030;

  localparam logic [31:0] CFG_RESET       = 32'h00200000;
  localparam logic [31:0] RDP_RESET       = 32'h00000000;
  localparam logic [31:0] CFG_WRITE_MASK  = 32'hffffff7f;
  localparam logic [31:0] RDP_WRITE_MASK  = 32'hfffffffc;

  localparam int unsigned TXQ_LSB         = 29;
  localparam int unsigned QUEUE_W         = 3;
  localparam int unsigned TBS_LSB         = 16;
  localparam int unsigned TBS_W           = 13;
  localparam int unsigned FWD_LSB         = 12;
  localparam int unsigned REFILL_LSB      = 8;
  localparam int unsigned RXQ_LSB         = 4;
  localparam int unsigned RXT_LSB         = 0;
  localparam int unsigned CODE_W          = 4;
  localparam int unsigned RDP_LSB         = 2;
  localparam int unsigned RDP_W           = 30;

  localparam int unsigned ST_ALLOC_BIT    = 16;
  localparam int unsigned ST_DESC_BIT     = 17;
  localparam int unsigned ST_REFILL_BAD   = 18;
  localparam int unsigned ST_RXT_BAD      = 19;
  localparam int unsigned ST_BURST_BIT    = 20;

  localparam int unsigned THR_W           = 10;
  localparam logic [3:0]  CODE_SHORT_MAX  = 4'h9;

  // Codes to DWORD counts; callers decide whether codes above nine are legal
  function automatic logic [9:0] threshold_dwords(input logic [3:0] code);
    logic [9:0] d;
    d = 10'h001;
    case (code)
      4'h0: d = 10'h001;
      4'h1: d = 10'h004;
      4'h2: d = 10'h008;
      4'h3: d = 10'h00c;
      4'h4: d = 10'h010;
      4'h5: d = 10'h018;
      4'h6: d = 10'h020;
      4'h7: d = 10'h028;
      4'h8: d = 10'h030;
      4'h9: d = 10'h040;
      4'ha: d = 10'h060;
      4'hb: d = 10'h080;
      4'hc: d = 10'h0c0;
      4'hd: d = 10'h100;
      4'he: d = 10'h180;
      4'hf: d = 10'h200;
      default: d = 10'h001;
    endcase
    return d;
  endfunction : threshold_dwords

  // Invalid short codes clamp to the largest legal entry
  function automatic logic [9:0] short_threshold_dwords(input logic [3:0] code);
    logic [9:0] d;
    d = threshold_dwords((code > CODE_SHORT_MAX) ? CODE_SHORT_MAX : code);
    return d;
  endfunction : short_threshold_dwords

endpackage : buffer_cfg_pkg

// ==== core/word_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ps
module word_fifo #(
  parameter int unsigned WIDTH = 33,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
    $error("word_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] count;
  } fifo_state_s;

  fifo_state_s        s;
  fifo_state_s        n;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               push;
  logic               pop;

  assign in_ready  = (s.count != CW'(DEPTH));
  assign out_valid = (s.count != '0);
  assign out_data  = mem[s.rd];

  always_comb begin
    n    = s;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      n.wr = s.wr + AW'(1);
    end
    if (pop) begin
      n.rd = s.rd + AW'(1);
    end
    n.count = s.count + CW'(push) - CW'(pop);
    if (flush) begin
      n = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Storage carries no reset; only the pointers define what is valid
  always_ff @(posedge clk) begin
    if (push && !flush) begin
      mem[s.wr] <= in_data;
    end
  end

endmodule : word_fifo

// ==== core/channel_buffer_threshold_config.sv ====
// Channel buffer configuration registers with transmit buffering, receive forwarding and descriptor fetch
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module channel_buffer_threshold_config #(
  parameter int unsigned TX_DEPTH = 32
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        tx_init_cmd,
  input  wire logic        tx_off_cmd,
  input  wire logic        tx_in_valid,
  output logic             tx_in_ready,
  input  wire logic [31:0] tx_in_data,
  input  wire logic        tx_in_last,
  output logic             tx_refill_req,
  output logic             pm_valid,
  input  wire logic        pm_ready,
  output logic [31:0]      pm_data,
  output logic             pm_last,
  input  wire logic        rx_word_valid,
  input  wire logic        rx_word_last,
  output logic             rx_forward,
  output logic [9:0]       rx_forward_words,
  input  wire logic        rx_abort_branch_cmd,
  output logic             desc_fetch_req,
  output logic [31:0]      desc_fetch_addr,
  input  wire logic        desc_fetch_ack,
  output logic [2:0]       tx_irq_queue_select,
  output logic [2:0]       rx_irq_queue_select
);
  localparam int unsigned FW  = 14;
  localparam int unsigned EW  = $clog2(TX_DEPTH + 2);
  localparam int unsigned DW  = 33;

  if (TX_DEPTH < 2 || TX_DEPTH > 4096) begin : g_bad_param
    $error("channel_buffer_threshold_config: TX_DEPTH must lie between 2 and 4096");
  end

  typedef struct packed {
    logic [31:0]   cfg;
    logic [29:0]   rdp;
    logic          alloc;
    logic [FW-1:0] fill;
    logic [EW-1:0] eop_cnt;
    logic          burst;
    logic          in_ready;
    logic          refill_req;
    logic          pm_valid;
    logic [31:0]   pm_data;
    logic          pm_last;
    logic [9:0]    rx_cnt;
    logic          rx_fwd;
    logic [9:0]    rx_fwd_words;
    logic          desc_loaded;
    logic          desc_req;
    logic [29:0]   desc_addr;
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
  } top_state_s;

  top_state_s        s;
  top_state_s        n;

  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [DW-1:0]     fifo_out_data;
  logic              push;
  logic              pop;
  logic              pm_take;
  logic              fwd_gate;
  logic [FW-1:0]     cap;
  logic [FW-1:0]     size14;
  logic [FW-1:0]     free14;
  logic [FW-1:0]     fwd_thr;
  logic [FW-1:0]     refill_thr;
  logic [9:0]        rx_thr;
  logic [9:0]        rx_next;
  logic              refill_bad;
  logic              rxt_bad;
  logic [31:0]       wmask;
  logic [31:0]       rdp_word;
  logic [31:0]       status_word;
  logic              apb_setup;
  logic              apb_write;

  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return m;
  endfunction : strobe_mask

  function automatic logic [3:0] cfg_code(input logic [31:0] cfg, input int unsigned lsb);
    logic [3:0] c;
    c = cfg[lsb +: 4];
    return c;
  endfunction : cfg_code

  word_fifo #(
    .WIDTH (DW),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .flush     (tx_off_cmd),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({tx_in_last, tx_in_data}),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    n           = s;
    size14      = FW'(s.cfg[buffer_cfg_pkg::TBS_LSB +: buffer_cfg_pkg::TBS_W]);
    // Configured size beyond the physical storage is served up to the storage only
    cap         = (size14 > FW'(TX_DEPTH + 1)) ? FW'(TX_DEPTH + 1) : size14;
    fwd_thr     = FW'(buffer_cfg_pkg::threshold_dwords(cfg_code(s.cfg, buffer_cfg_pkg::FWD_LSB)));
    refill_thr  = FW'(buffer_cfg_pkg::short_threshold_dwords(cfg_code(s.cfg, buffer_cfg_pkg::REFILL_LSB)));
    rx_thr      = buffer_cfg_pkg::short_threshold_dwords(cfg_code(s.cfg, buffer_cfg_pkg::RXT_LSB));
    refill_bad  = cfg_code(s.cfg, buffer_cfg_pkg::REFILL_LSB) > buffer_cfg_pkg::CODE_SHORT_MAX;
    rxt_bad     = cfg_code(s.cfg, buffer_cfg_pkg::RXT_LSB) > buffer_cfg_pkg::CODE_SHORT_MAX;
    free14      = '0;
    rx_next     = s.rx_cnt + 10'h001;
    wmask       = strobe_mask(pstrb);
    rdp_word    = ({s.rdp, 2'b00} & ~wmask) | (pwdata & wmask);
    apb_setup   = psel && !penable;
    apb_write   = psel && penable && s.pready && pwrite;

    // Transmit path
    push        = tx_in_valid && s.in_ready && fifo_in_ready;
    pm_take     = s.pm_valid && pm_ready;
    fwd_gate    = s.burst || (s.fill >= fwd_thr) || (s.eop_cnt != '0);
    pop         = fifo_out_valid && (!s.pm_valid || pm_ready) && fwd_gate && s.alloc;
    n.fill      = s.fill + FW'(push) - FW'(pm_take);
    n.eop_cnt   = s.eop_cnt + EW'(push && tx_in_last) - EW'(pm_take && s.pm_last);
    if (pop) begin
      n.pm_valid = 1'b1;
      n.pm_data  = fifo_out_data[31:0];
      n.pm_last  = fifo_out_data[32];
      // Once started, a packet keeps flowing until its end leaves the buffer
      n.burst    = !fifo_out_data[32];
    end else if (pm_take) begin
      n.pm_valid = 1'b0;
    end
    if (tx_init_cmd) begin
      n.alloc = 1'b1;
    end
    if (tx_off_cmd) begin
      n.alloc    = 1'b0;
      n.fill     = '0;
      n.eop_cnt  = '0;
      n.burst    = 1'b0;
      n.pm_valid = 1'b0;
      n.pm_last  = 1'b0;
    end
    n.in_ready   = n.alloc && (n.fill < cap);
    free14       = (cap > n.fill) ? (cap - n.fill) : '0;
    n.refill_req = n.alloc && (free14 >= refill_thr);

    // Receive path
    n.rx_fwd = 1'b0;
    if (rx_word_valid) begin
      if (rx_next >= rx_thr || rx_word_last) begin
        n.rx_fwd       = 1'b1;
        n.rx_fwd_words = rx_next;
        n.rx_cnt       = '0;
      end else begin
        n.rx_cnt = rx_next;
      end
      if (!s.desc_loaded && !s.desc_req) begin
        n.desc_req  = 1'b1;
        n.desc_addr = s.rdp;
      end
    end
    if (s.desc_req && desc_fetch_ack) begin
      n.desc_req    = 1'b0;
      n.desc_loaded = 1'b1;
    end
    // Abort/branch drops the held descriptor so the next request starts a new list
    if (rx_abort_branch_cmd) begin
      n.desc_req    = 1'b0;
      n.desc_loaded = 1'b0;
      n.rx_cnt      = '0;
    end

    // APB slave: one access cycle, errors on unmapped addresses
    status_word = '0;
    status_word[FW-1:0]                       = s.fill;
    status_word[buffer_cfg_pkg::ST_ALLOC_BIT]  = s.alloc;
    status_word[buffer_cfg_pkg::ST_DESC_BIT]   = s.desc_loaded;
    status_word[buffer_cfg_pkg::ST_REFILL_BAD] = refill_bad;
    status_word[buffer_cfg_pkg::ST_RXT_BAD]    = rxt_bad;
    status_word[buffer_cfg_pkg::ST_BURST_BIT]  = s.burst;
    n.pready = apb_setup;
    if (apb_setup) begin
      n.pslverr = 1'b0;
      case (paddr)
        buffer_cfg_pkg::CFG_OFFSET: begin
          n.prdata = s.cfg & buffer_cfg_pkg::CFG_WRITE_MASK;
        end
        buffer_cfg_pkg::RDP_OFFSET: begin
          n.prdata = {s.rdp, 2'b00};
        end
        buffer_cfg_pkg::STATUS_OFFSET: begin
          n.prdata = status_word;
        end
        default: begin
          n.prdata  = '0;
          n.pslverr = 1'b1;
        end
      endcase
    end else if (!psel) begin
      n.pslverr = 1'b0;
    end
    if (apb_write) begin
      case (paddr)
        buffer_cfg_pkg::CFG_OFFSET: begin
          n.cfg = ((s.cfg & ~wmask) | (pwdata & wmask)) & buffer_cfg_pkg::CFG_WRITE_MASK;
        end
        buffer_cfg_pkg::RDP_OFFSET: begin
          n.rdp = rdp_word[31:buffer_cfg_pkg::RDP_LSB];
        end
        default: begin
          n.cfg = s.cfg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s     <= '0;
      s.cfg <= buffer_cfg_pkg::CFG_RESET;
      s.rdp <= buffer_cfg_pkg::RDP_RESET[31:2];
    end else begin
      s <= n;
    end
  end

  assign pready              = s.pready;
  assign prdata              = s.prdata;
  assign pslverr             = s.pslverr;
  assign tx_in_ready         = s.in_ready;
  assign tx_refill_req       = s.refill_req;
  assign pm_valid            = s.pm_valid;
  assign pm_data             = s.pm_data;
  assign pm_last             = s.pm_last;
  assign rx_forward          = s.rx_fwd;
  assign rx_forward_words    = s.rx_fwd_words;
  assign desc_fetch_req      = s.desc_req;
  assign desc_fetch_addr     = {s.desc_addr, 2'b00};
  assign tx_irq_queue_select = s.cfg[buffer_cfg_pkg::TXQ_LSB +: buffer_cfg_pkg::QUEUE_W];
  assign rx_irq_queue_select = s.cfg[buffer_cfg_pkg::RXQ_LSB +: buffer_cfg_pkg::QUEUE_W];

endmodule : channel_buffer_threshold_config

// ==== verification/buffer_cfg_checker.sv ====
// Port-level assertions for the channel buffer block
`timescale 1ns/1ps
module buffer_cfg_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        tx_init_cmd,
  input wire logic        tx_off_cmd,
  input wire logic        tx_in_ready,
  input wire logic        pm_valid,
  input wire logic        pm_ready,
  input wire logic [31:0] pm_data,
  input wire logic        rx_word_valid,
  input wire logic        rx_word_last,
  input wire logic        rx_forward,
  input wire logic        rx_abort_branch_cmd,
  input wire logic        desc_fetch_req,
  input wire logic [31:0] desc_fetch_addr,
  input wire logic        desc_fetch_ack,
  input wire logic [2:0]  tx_irq_queue_select,
  input wire logic [2:0]  rx_irq_queue_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_cfg_wr;
    psel && penable && pready && pwrite && paddr == buffer_cfg_pkg::CFG_OFFSET && pstrb == 4'hf;
  endsequence
  sequence s_fetch_wait;
    desc_fetch_req && !desc_fetch_ack && !rx_abort_branch_cmd;
  endsequence
  a_pready_setup: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single pulse after setup");
  a_tx_queue_set: assert property (s_cfg_wr |=> tx_irq_queue_select == $past(pwdata[31:29]))
    else $error("tx queue select not updated");
  a_rx_queue_set: assert property (s_cfg_wr |=> rx_irq_queue_select == $past(pwdata[6:4]))
    else $error("rx queue select not updated");
  a_reserved_zero: assert property (psel && penable && pready && !pwrite && paddr == 12'h020 |-> !prdata[7])
    else $error("reserved bit reads one");
  a_fetch_align: assert property (desc_fetch_req |-> desc_fetch_addr[1:0] == 2'b00)
    else $error("fetch address not word aligned");
  a_fetch_hold: assert property (s_fetch_wait |=> desc_fetch_req && $stable(desc_fetch_addr))
    else $error("fetch request dropped before ack");
  a_rx_last_fwd: assert property (rx_word_valid && rx_word_last |=> rx_forward)
    else $error("packet end not forwarded");
  a_pm_hold: assert property (pm_valid && !pm_ready && !tx_off_cmd |=> pm_valid && $stable(pm_data))
    else $error("transmit word changed while stalled");
  a_off_release: assert property (tx_off_cmd ##1 !tx_init_cmd |-> !tx_in_ready ##1 !tx_in_ready)
    else $error("buffer still accepts after off");
endmodule : buffer_cfg_checker

bind channel_buffer_threshold_config buffer_cfg_checker u_chk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .tx_init_cmd(tx_init_cmd),
  .tx_off_cmd(tx_off_cmd),
  .tx_in_ready(tx_in_ready), .pm_valid(pm_valid), .pm_ready(pm_ready), .pm_data(pm_data),
  .rx_word_valid(rx_word_valid), .rx_word_last(rx_word_last), .rx_forward(rx_forward),
  .rx_abort_branch_cmd(rx_abort_branch_cmd), .desc_fetch_req(desc_fetch_req),
  .desc_fetch_addr(desc_fetch_addr), .desc_fetch_ack(desc_fetch_ack),
  .tx_irq_queue_select(tx_irq_queue_select), .rx_irq_queue_select(rx_irq_queue_select)
);

// ==== verification/desc_memory_model.sv ====
// System memory model answering receive descriptor fetches
`timescale 1ns/1ps
module desc_memory_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        desc_fetch_req,
  input  wire logic [31:0] desc_fetch_addr,
  output logic             desc_fetch_ack,
  output logic [31:0]      mem_addr,
  output logic [7:0]       mem_count
);
  logic [3:0] wait_r;
  // Descriptors are always complete in memory, so any fetch may be answered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= '0;
      desc_fetch_ack <= 1'b0;
      mem_addr <= '0;
      mem_count <= '0;
    end else if (desc_fetch_ack || !desc_fetch_req) begin
      desc_fetch_ack <= 1'b0;
      wait_r <= '0;
    end else if (wait_r >= ack_delay) begin
      desc_fetch_ack <= 1'b1;
      mem_addr <= desc_fetch_addr;
      mem_count <= mem_count + 8'h01;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : desc_memory_model

// ==== verification/tb.sv ====
// Self-checking testbench for the channel buffer block
`timescale 1ns/1ps
module tb;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e; logic [2:0] tq; logic [2:0] rq;} row_s;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic        tx_init_cmd, tx_off_cmd, tx_in_valid, tx_in_ready, tx_in_last, tx_refill_req;
  logic        pm_valid, pm_ready, pm_last, rx_word_valid, rx_word_last, rx_forward;
  logic        rx_abort_branch_cmd, desc_fetch_req, desc_fetch_ack;
  logic [2:0]  tx_irq_queue_select, rx_irq_queue_select;
  logic [3:0]  pstrb, ack_delay;
  logic [7:0]  mem_count;
  logic [9:0]  rx_forward_words;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, tx_in_data, pm_data, desc_fetch_addr, mem_addr, rd;
  int          failures, check_count, cycles, n, k, fw;
  row_s        rows [4] = '{'{12'h020, 32'ha0200035, 32'ha0200035, 1'b0, 3'h5, 3'h3},
                            '{12'h020, 32'h5f2000ca, 32'h5f20004a, 1'b0, 3'h2, 3'h4},
                            '{12'h024, 32'h12345677, 32'h12345674, 1'b0, 3'h2, 3'h4},
                            '{12'h0fc, 32'h00000000, 32'h00000000, 1'b1, 3'h2, 3'h4}};
  logic [9:0]  rx_dw [11] = '{10'h001, 10'h004, 10'h008, 10'h00c, 10'h010, 10'h018, 10'h020,
                              10'h028, 10'h030, 10'h040, 10'h040};

  channel_buffer_threshold_config u_dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .tx_init_cmd(tx_init_cmd), .tx_off_cmd(tx_off_cmd), .tx_in_valid(tx_in_valid),
    .tx_in_ready(tx_in_ready), .tx_in_data(tx_in_data), .tx_in_last(tx_in_last),
    .tx_refill_req(tx_refill_req), .pm_valid(pm_valid), .pm_ready(pm_ready), .pm_data(pm_data),
    .pm_last(pm_last), .rx_word_valid(rx_word_valid), .rx_word_last(rx_word_last),
    .rx_forward(rx_forward), .rx_forward_words(rx_forward_words),
    .rx_abort_branch_cmd(rx_abort_branch_cmd), .desc_fetch_req(desc_fetch_req),
    .desc_fetch_addr(desc_fetch_addr), .desc_fetch_ack(desc_fetch_ack),
    .tx_irq_queue_select(tx_irq_queue_select), .rx_irq_queue_select(rx_irq_queue_select));
  desc_memory_model u_mem (
    .clk(clk), .rst_b(rst_b), .ack_delay(ack_delay), .desc_fetch_req(desc_fetch_req),
    .desc_fetch_addr(desc_fetch_addr), .desc_fetch_ack(desc_fetch_ack), .mem_addr(mem_addr),
    .mem_count(mem_count));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_pm();
    n = 0;
    while (pm_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_pm

  initial begin
    {psel, penable, pwrite, tx_init_cmd, tx_off_cmd, tx_in_valid, tx_in_last, pm_ready} = '0;
    {rx_word_valid, rx_word_last, rx_abort_branch_cmd, paddr, pwdata, pstrb, tx_in_data} = '0;
    ack_delay = 4'h0;
    rst_b = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      chk(er, rows[i].e, "error response");
      apb(1'b0, rows[i].a, 32'h0);
      if (!rows[i].e) chk(rd, rows[i].r, "readback");
      chk(tx_irq_queue_select, rows[i].tq, "tx queue");
      chk(rx_irq_queue_select, rows[i].rq, "rx queue");
    end
    $display("register rows done");
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h00200000, "cfg reset");
    apb(1'b0, 12'h024, 32'h0);
    chk(rd, 32'h00000000, "pointer reset");
    chk(tx_in_ready, 1'b0, "ready before init");
    $display("reset test done");
    apb(1'b1, 12'h024, 32'h00001233);
    for (int c = 0; c < 11; c++) begin
      apb(1'b1, 12'h020, 32'h00200000 | 32'(c));
      fw = 0;
      rx_word_valid <= 1'b1;
      repeat (rx_dw[c]) begin
        @(posedge clk);
        if (rx_forward !== 1'b0) fw++;
      end
      rx_word_valid <= 1'b0;
      @(posedge clk);
      chk(fw, 0, "early rx forward");
      chk(rx_forward, 1'b1, "rx forward");
      chk(rx_forward_words, rx_dw[c], "rx forward size");
    end
    chk(mem_addr, 32'h00001230, "fetch address");
    chk(mem_count, 8'h01, "single fetch");
    rx_word_valid <= 1'b1;
    @(posedge clk);
    rx_word_last <= 1'b1;
    @(posedge clk);
    rx_word_valid <= 1'b0;
    rx_word_last <= 1'b0;
    @(posedge clk);
    chk(rx_forward, 1'b1, "packet end forward");
    chk(rx_forward_words, 10'h002, "packet end size");
    apb(1'b1, 12'h024, 32'h0000abc3);
    ack_delay <= 4'h5;
    rx_abort_branch_cmd <= 1'b1;
    @(posedge clk);
    rx_abort_branch_cmd <= 1'b0;
    rx_word_valid <= 1'b1;
    @(posedge clk);
    rx_word_valid <= 1'b0;
    k = 0;
    while (mem_count !== 8'h02 && k < 30) begin
      @(posedge clk);
      k++;
    end
    chk(mem_addr, 32'h0000abc0, "branch fetch address");
    $display("receive tests done");
    apb(1'b1, 12'h020, 32'h00141100);
    tx_init_cmd <= 1'b1;
    @(posedge clk);
    tx_init_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    chk(tx_refill_req, 1'b1, "refill when empty");
    k = 0;
    tx_in_valid <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (k < 4 && pm_valid !== 1'b0) chk(pm_valid, 1'b0, "forward below threshold");
      if (tx_in_ready === 1'b1) begin
        k++;
        tx_in_data <= 32'(k);
        tx_in_last <= (k == 19);
      end
    end
    tx_in_valid <= 1'b0;
    chk(k, 20, "buffer capacity");
    chk(tx_refill_req, 1'b0, "refill when full");
    chk(pm_valid, 1'b1, "forward at threshold");
    apb(1'b0, 12'h030, 32'h0);
    chk(rd, 32'h00130014, "status when full");
    pm_ready <= 1'b1;
    k = 0;
    repeat (40) begin
      @(posedge clk);
      if (pm_valid === 1'b1) begin
        chk(pm_data, 32'(k), "drain order");
        k++;
      end
    end
    chk(k, 20, "drained words");
    chk(tx_refill_req, 1'b1, "refill after drain");
    tx_in_valid <= 1'b1;
    tx_in_last <= 1'b1;
    tx_in_data <= 32'h0000beef;
    do @(posedge clk); while (tx_in_ready !== 1'b1);
    tx_in_valid <= 1'b0;
    tx_in_last <= 1'b0;
    wait_pm();
    chk(pm_data, 32'h0000beef, "short packet data");
    chk(pm_last, 1'b1, "short packet end");
    tx_off_cmd <= 1'b1;
    @(posedge clk);
    tx_off_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    chk(tx_in_ready, 1'b0, "released after off");
    $display("transmit tests done");
    end_of_test();
  end
endmodule : tb
